//--- rtl/lcs_link_control_status.sv
`timescale 1ns/1ns
// Notes on behaviour
// RULE1 - Status bit 27 flags receive buffer overflow or illegal token received.
// RULE2 - Read-only bit 26, reset zero, shows credit granted to the remote end.
// RULE3 - Read-only bit 25, reset zero, shows credit held to transmit.
// RULE4 - Writing one to bit 24 drops held credit and sends credit request.
// RULE5 - Writing one to bit 23 resets receiver; next symbol starts a token.
// RULE6 - At least symbol-gap field plus one idle cycles between token symbols.
// RULE7 - At least token-gap field plus one idle cycles between tokens.
// RULE8 - Two output wires and two input wires cross-connected to partner.
// RULE9 - Bits 24 and 23 are one-cycle strobes; reserved bits ignored on write.
module lcs_link_control_status (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Two-wire link, one symbol per cycle when nonzero
   output logic [1:0] link_port_zero_out,
   input wire logic [1:0] link_port_zero_in,
   // Data token user side
   input wire logic tx_data_valid,
   output logic tx_data_ready,
   output logic rx_data_pulse,
   input wire logic rx_data_take,
   // Interrupt
   output logic irq
);
   // ==========================================
   // State
   typedef struct packed {
      logic [31:0] rdata;
      logic [10:0] sym_gap;
      logic [10:0] tok_gap;
      logic err;
      logic issued;
      logic held;
      logic req_pend;
      logic cred_pend;
      lcs_pkg::lcs_tx_t tx_st;
      logic [5:0] tx_tok;
      logic [1:0] tx_idx;
      logic [10:0] gap_cnt;
      logic [1:0] out;
      logic [5:0] rx_sh;
      logic [1:0] rx_idx;
      logic [3:0] rx_fill;
      logic rx_pulse;
      logic [2:0] ist;
      logic [2:0] ien;
   } lcs_state_t;

   lcs_state_t s_r, s_nxt;

   // Word select helper, used by both read and write decode
   function automatic logic lcs_hit(input logic [7:0] a, input logic [7:0] ofs);
      lcs_hit = (a == ofs);
   endfunction : lcs_hit

   logic wr_ctrl, credit_request_token_stb, rxrst_stb, tok_done, tx_go;
   logic [5:0] rx_word;
   logic rx_last, rx_illegal, rx_ovf;
   logic [2:0] ev;

   // ==========================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.rx_pulse = 1'b0;
      wr_ctrl = reg_wr && lcs_hit(reg_addr, lcs_pkg::LCS_CTRL_OFS);
      credit_request_token_stb = wr_ctrl && reg_wdata[lcs_pkg::LCS_CREDIT_REQUEST_TOKEN_BIT]; // [RULE9]
      rxrst_stb = wr_ctrl && reg_wdata[lcs_pkg::LCS_RXRST_BIT]; // [RULE9]
      tok_done = 1'b0;
      tx_go = 1'b0;
      rx_word = {s_r.rx_sh[3:0], link_port_zero_in};
      rx_last = (link_port_zero_in != 2'b00) && (s_r.rx_idx == 2'(lcs_pkg::LCS_SYMS - 1));
      rx_illegal = 1'b0;
      rx_ovf = 1'b0;
      ev = 3'b000;

      // Gap fields only; reserved bits and strobes keep no stored value
      if (wr_ctrl) begin
         s_nxt.sym_gap = reg_wdata[lcs_pkg::LCS_SYMGAP_LSB +: lcs_pkg::LCS_GAP_W]; // [RULE9]
         s_nxt.tok_gap = reg_wdata[lcs_pkg::LCS_TOKGAP_LSB +: lcs_pkg::LCS_GAP_W];
      end

      // Credit request drops held credit and queues a request token
      if (credit_request_token_stb) begin
         s_nxt.held = 1'b0; // [RULE4]
         s_nxt.req_pend = 1'b1; // [RULE4]
      end

      // Receiver: one symbol per nonzero input cycle
      if (rxrst_stb) begin
         s_nxt.rx_idx = 2'b00; // [RULE5]
         s_nxt.rx_sh = 6'h00;
      end else if (link_port_zero_in != 2'b00) begin // [RULE8]
         s_nxt.rx_sh = rx_word;
         s_nxt.rx_idx = rx_last ? 2'b00 : s_r.rx_idx + 2'b01;
         if (rx_last) begin
            case (rx_word)
               lcs_pkg::LCS_TOK_REQ: begin
                  // Remote asks for credit: queue a grant at once, without checking buffer room
                  s_nxt.cred_pend = 1'b1;
                  ev[lcs_pkg::LCS_IRQ_REQ] = 1'b1;
               end
               lcs_pkg::LCS_TOK_CREDIT: begin
                  s_nxt.held = 1'b1; // [RULE3]
                  ev[lcs_pkg::LCS_IRQ_CREDIT] = 1'b1;
               end
               lcs_pkg::LCS_TOK_DATA: begin
                  if (!s_r.issued || s_r.rx_fill == lcs_pkg::LCS_RXBUF_MAX) begin
                     rx_ovf = 1'b1;
                  end else begin
                     s_nxt.rx_fill = s_r.rx_fill + 4'h1;
                     s_nxt.rx_pulse = 1'b1;
                  end
               end
               default: rx_illegal = 1'b1;
            endcase
         end
      end

      // Consumer frees buffer space
      if (rx_data_take && s_nxt.rx_fill != 4'h0) begin
         s_nxt.rx_fill = s_nxt.rx_fill - 4'h1;
      end

      // Error is sticky until reset
      if (rx_ovf || rx_illegal) begin
         s_nxt.err = 1'b1; // [RULE1]
         ev[lcs_pkg::LCS_IRQ_ERR] = 1'b1;
      end

      // Transmitter
      s_nxt.out = 2'b00;
      case (s_r.tx_st)
         lcs_pkg::LCS_TX_IDLE: begin
            if (s_r.req_pend) begin
               s_nxt.tx_tok = lcs_pkg::LCS_TOK_REQ;
               s_nxt.req_pend = credit_request_token_stb;
               tx_go = 1'b1;
            end else if (s_r.cred_pend) begin
               s_nxt.tx_tok = lcs_pkg::LCS_TOK_CREDIT;
               s_nxt.cred_pend = ev[lcs_pkg::LCS_IRQ_REQ]; // A request landing now stays queued
               s_nxt.issued = 1'b1; // [RULE2]
               tx_go = 1'b1;
            end else if (tx_data_valid && s_r.held) begin
               s_nxt.tx_tok = lcs_pkg::LCS_TOK_DATA;
               tx_go = 1'b1;
            end
            if (tx_go) begin
               s_nxt.tx_st = lcs_pkg::LCS_TX_SYM;
               s_nxt.tx_idx = 2'b00;
            end
         end
         lcs_pkg::LCS_TX_SYM: begin
            s_nxt.out = s_r.tx_tok[5 - 2 * s_r.tx_idx -: 2]; // [RULE8]
            s_nxt.gap_cnt = 11'h000;
            if (s_r.tx_idx == 2'(lcs_pkg::LCS_SYMS - 1)) begin
               s_nxt.tx_st = lcs_pkg::LCS_TX_TGAP;
               tok_done = 1'b1;
            end else begin
               s_nxt.tx_st = lcs_pkg::LCS_TX_SGAP;
               s_nxt.tx_idx = s_r.tx_idx + 2'b01;
            end
         end
         lcs_pkg::LCS_TX_SGAP: begin
            // Count field+1 idle cycles after the symbol cycle
            s_nxt.gap_cnt = s_r.gap_cnt + 11'h001;
            if (s_r.gap_cnt == s_r.sym_gap) begin // [RULE6]
               s_nxt.tx_st = lcs_pkg::LCS_TX_SYM;
            end
         end
         lcs_pkg::LCS_TX_TGAP: begin
            s_nxt.gap_cnt = s_r.gap_cnt + 11'h001;
            if (s_r.gap_cnt == s_r.tok_gap) begin // [RULE7]
               s_nxt.tx_st = lcs_pkg::LCS_TX_IDLE;
            end
         end
         default: s_nxt.tx_st = lcs_pkg::LCS_TX_IDLE;
      endcase

      // Interrupt status: set wins over clear
      if (reg_wr && lcs_hit(reg_addr, lcs_pkg::LCS_IRQ_CLR_OFS)) begin
         s_nxt.ist = s_r.ist & ~reg_wdata[2:0];
      end
      s_nxt.ist = s_nxt.ist | ev;
      if (reg_wr && lcs_hit(reg_addr, lcs_pkg::LCS_IRQ_EN_OFS)) begin
         s_nxt.ien = reg_wdata[2:0];
      end

      // Read data, one cycle later; unmapped reads zero
      s_nxt.rdata = 32'h0000_0000;
      if (reg_rd) begin
         if (lcs_hit(reg_addr, lcs_pkg::LCS_CTRL_OFS)) begin
            s_nxt.rdata[lcs_pkg::LCS_ERR_BIT] = s_r.err; // [RULE1]
            s_nxt.rdata[lcs_pkg::LCS_ISSUED_BIT] = s_r.issued; // [RULE2]
            s_nxt.rdata[lcs_pkg::LCS_HELD_BIT] = s_r.held; // [RULE3]
            s_nxt.rdata[lcs_pkg::LCS_SYMGAP_LSB +: lcs_pkg::LCS_GAP_W] = s_r.sym_gap;
            s_nxt.rdata[lcs_pkg::LCS_TOKGAP_LSB +: lcs_pkg::LCS_GAP_W] = s_r.tok_gap;
         end else if (lcs_hit(reg_addr, lcs_pkg::LCS_IRQ_STAT_OFS)) begin
            s_nxt.rdata[2:0] = s_r.ist;
         end else if (lcs_hit(reg_addr, lcs_pkg::LCS_IRQ_EN_OFS)) begin
            s_nxt.rdata[2:0] = s_r.ien;
         end
      end

      if (srst) begin
         s_nxt = '0;
         s_nxt.sym_gap = lcs_pkg::LCS_GAP_RST;
         s_nxt.tok_gap = lcs_pkg::LCS_GAP_RST;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge ref_clk) begin
      s_r <= s_nxt;
   end

   // Outputs
   assign reg_rdata = s_r.rdata;
   assign link_port_zero_out = s_r.out;
   assign tx_data_ready = tok_done && (s_r.tx_tok == lcs_pkg::LCS_TOK_DATA);
   assign rx_data_pulse = s_r.rx_pulse;
   assign irq = |(s_r.ist & s_r.ien);

   // ==========================================
   // Checks
   // Idle run and symbol position as seen on the output wires, counted apart
   // from the gap counter so that a broken counter cannot hide itself
   logic [11:0] chk_idle_r;
   logic [1:0] chk_pos_r;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         chk_idle_r <= 12'hFFF;
         chk_pos_r <= 2'b00;
      end else if (link_port_zero_out == 2'b00) begin
         // Saturate so a long quiet spell never wraps to a short one
         if (chk_idle_r != 12'hFFF) begin
            chk_idle_r <= chk_idle_r + 12'h001;
         end
      end else begin
         chk_idle_r <= 12'h000;
         chk_pos_r <= (chk_pos_r == 2'(lcs_pkg::LCS_SYMS - 1)) ? 2'b00 : chk_pos_r + 2'b01;
      end
   end

   // Gap fields are read live; a write in mid-token moves the bound with it
   property p_sym_gap;
      @(posedge ref_clk) disable iff (srst)
      (link_port_zero_out != 2'b00 && chk_pos_r != 2'b00)
         |-> chk_idle_r > {1'b0, s_r.sym_gap};
   endproperty
   a_sym_gap: assert property (p_sym_gap) else $error("symbol gap too short"); // [RULE6]

   property p_tok_gap;
      @(posedge ref_clk) disable iff (srst)
      (link_port_zero_out != 2'b00 && chk_pos_r == 2'b00)
         |-> chk_idle_r > {1'b0, s_r.tok_gap};
   endproperty
   a_tok_gap: assert property (p_tok_gap) else $error("token gap too short"); // [RULE7]

   // A credit arriving in the same cycle wins over the clear
   property p_credit_request_token;
      @(posedge ref_clk) disable iff (srst)
      (credit_request_token_stb && !ev[lcs_pkg::LCS_IRQ_CREDIT]) |=> !s_r.held && s_r.req_pend;
   endproperty
   a_credit_request_token: assert property (p_credit_request_token) else $error("credit request not taken"); // [RULE4]

   property p_rxrst;
      @(posedge ref_clk) disable iff (srst)
      rxrst_stb |=> s_r.rx_idx == 2'b00;
   endproperty
   a_rxrst: assert property (p_rxrst) else $error("receiver not reset"); // [RULE5]

   property p_err;
      @(posedge ref_clk) disable iff (srst)
      (rx_illegal || rx_ovf) |=> s_r.err;
   endproperty
   a_err: assert property (p_err) else $error("error flag not set"); // [RULE1]

   property p_held;
      @(posedge ref_clk) disable iff (srst)
      (s_r.tx_st == lcs_pkg::LCS_TX_IDLE && s_nxt.tx_tok == lcs_pkg::LCS_TOK_DATA && tx_go) |-> s_r.held;
   endproperty
   a_held: assert property (p_held) else $error("data sent without credit"); // [RULE3]

   property p_issued;
      @(posedge ref_clk) disable iff (srst)
      $rose(s_r.issued) |-> ##[1:3] link_port_zero_out != 2'b00;
   endproperty
   a_issued: assert property (p_issued) else $error("credit not sent"); // [RULE2]

   property p_strobe;
      @(posedge ref_clk) disable iff (srst)
      wr_ctrl |=> s_r.sym_gap == $past(reg_wdata[21:11]) && s_r.tok_gap == $past(reg_wdata[10:0]);
   endproperty
   a_strobe: assert property (p_strobe) else $error("gap fields not stored"); // [RULE9]

   // A request arriving while a grant goes out must stay queued
   property p_cred_grant;
      @(posedge ref_clk) disable iff (srst)
      ev[lcs_pkg::LCS_IRQ_REQ] |=> s_r.cred_pend;
   endproperty
   a_cred_grant: assert property (p_cred_grant) else $error("credit grant lost"); // [RULE2]

   property p_err_hold;
      @(posedge ref_clk) disable iff (srst)
      s_r.err |=> s_r.err;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag dropped"); // [RULE1]

   property p_issued_hold;
      @(posedge ref_clk) disable iff (srst)
      s_r.issued |=> s_r.issued;
   endproperty
   a_issued_hold: assert property (p_issued_hold) else $error("granted flag dropped"); // [RULE2]

   property p_rsvd;
      @(posedge ref_clk) disable iff (srst)
      reg_rd |=> reg_rdata[31:28] == 4'h0 && reg_rdata[24:22] == 3'b000;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved or strobe bits read back"); // [RULE9]

   property p_idle_out;
      @(posedge ref_clk) disable iff (srst)
      s_r.tx_st == lcs_pkg::LCS_TX_IDLE |=> link_port_zero_out == 2'b00;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("symbol sent between tokens"); // [RULE7]

   property p_rxclr;
      @(posedge ref_clk) disable iff (srst)
      rxrst_stb |=> s_r.rx_sh == 6'h00;
   endproperty
   a_rxclr: assert property (p_rxclr) else $error("partial token kept"); // [RULE5]
endmodule : lcs_link_control_status

//--- rtl/lcs_pkg.sv
package lcs_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0] LCS_CTRL_OFS = 8'h80;
   localparam logic [7:0] LCS_IRQ_STAT_OFS = 8'h84;
   localparam logic [7:0] LCS_IRQ_EN_OFS = 8'h88;
   localparam logic [7:0] LCS_IRQ_CLR_OFS = 8'h8C;
   // ==========================================
   // Field positions
   localparam int LCS_ERR_BIT = 27;
   localparam int LCS_ISSUED_BIT = 26;
   localparam int LCS_HELD_BIT = 25;
   localparam int LCS_CREDIT_REQUEST_TOKEN_BIT = 24;
   localparam int LCS_RXRST_BIT = 23;
   localparam int LCS_SYMGAP_LSB = 11;
   localparam int LCS_TOKGAP_LSB = 0;
   localparam int LCS_GAP_W = 11;
   // ==========================================
   // Reset values
   localparam logic [10:0] LCS_GAP_RST = 11'h001;
   // ==========================================
   // Token codes on the two-wire link (3 symbols, 2 bits each)
   localparam logic [5:0] LCS_TOK_REQ = 6'h39;
   localparam logic [5:0] LCS_TOK_CREDIT = 6'h1B;
   // Every symbol of a token must be nonzero, or the receiver never sees it end
   localparam logic [5:0] LCS_TOK_DATA = 6'h26;
   localparam int LCS_SYMS = 3;
   // Receive buffer depth in tokens
   localparam logic [3:0] LCS_RXBUF_MAX = 4'h8;
   // Interrupt layout
   localparam int LCS_IRQ_ERR = 0;
   localparam int LCS_IRQ_CREDIT = 1;
   localparam int LCS_IRQ_REQ = 2;

   typedef enum logic [1:0] {
      LCS_TX_IDLE = 2'b00,
      LCS_TX_SYM = 2'b01,
      LCS_TX_SGAP = 2'b10,
      LCS_TX_TGAP = 2'b11
   } lcs_tx_t;
endpackage : lcs_pkg

//--- testbench/lcs_far_end.sv
`timescale 1ns/1ns
// ==========================================
// Far end of the two-wire link
module lcs_far_end (
   // Clock
   input wire logic ref_clk,
   // Wires crossed with the block under test
   input wire logic [1:0] from_dut,
   output logic [1:0] to_dut
);
   int idle = 0;
   int nsym = 0;
   int ntok = 0;
   int sgap_min = 999;
   int tgap_min = 999;
   logic [5:0] sh = 6'h00;
   logic [5:0] last_tok = 6'h00;
   initial to_dut = 2'b00;
   // Send n symbols MSB first, three idle cycles after each one
   task send(input logic [5:0] t, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         to_dut <= t[5-2*i -: 2];
         @(posedge ref_clk);
         to_dut <= 2'b00;
         repeat (2) @(posedge ref_clk);
      end
   endtask : send
   // Forget earlier traffic before a new scenario
   task clr;
      ntok = 0;
      nsym = 0;
      sgap_min = 999;
      tgap_min = 999;
   endtask : clr
   // Collect tokens and the shortest idle runs between symbols and tokens
   always @(posedge ref_clk) begin
      if (from_dut == 2'b00) begin
         idle = idle + 1;
      end else begin
         if (nsym > 0 && idle < sgap_min) sgap_min = idle;
         if (nsym == 0 && ntok > 0 && idle < tgap_min) tgap_min = idle;
         sh = {sh[3:0], from_dut};
         idle = 0;
         nsym = nsym + 1;
         if (nsym == 3) begin
            last_tok = sh;
            ntok = ntok + 1;
            nsym = 0;
         end
      end
   end
endmodule : lcs_far_end

//--- testbench/test_link_control_status.sv
`timescale 1ns/1ns
// ==========================================
// Bench for the link control and status block
module test_link_control_status;
   logic ref_clk, srst, reg_wr, reg_rd, irq;
   logic tx_data_valid, tx_data_ready, rx_data_pulse;
   int n_rx = 0;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [1:0] a2b, b2a;
   int n_errors = 0;
   int n_compared = 0;
   lcs_link_control_status DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_port_zero_out(a2b),
      .link_port_zero_in(b2a), .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready),
      .rx_data_pulse(rx_data_pulse),
      .rx_data_take(1'b0), .irq(irq));
   lcs_far_end FAR (.ref_clk(ref_clk), .from_dut(a2b), .to_dut(b2a));
   // Data tokens handed to the user side
   always @(posedge ref_clk) begin
      if (rx_data_pulse === 1'b1) n_rx++;
   end
   // ==========================================
   // Bus cycles and comparison
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (e !== g) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Bounded wait for the far end to collect n tokens
   task wait_tok(input int n);
      for (int i = 0; i < 300 && FAR.ntok < n; i++) @(posedge ref_clk);
      chk("tokens", n, FAR.ntok);
   endtask : wait_tok
   task conclude;
      if (n_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   // ==========================================
   // Scenarios
   task t_reset;
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("ctrl_reset", 32'h0000_0801, d);
      rd(8'h00);
      chk("unmapped", 32'h0000_0000, d);
   endtask : t_reset
   // Reserved bits set on purpose must not stick
   task t_gaps;
      wr(lcs_pkg::LCS_CTRL_OFS, 32'hF040_1802);
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("ctrl_gaps", 32'h0000_1802, d);
   endtask : t_gaps
   task t_grant;
      FAR.clr();
      FAR.send(lcs_pkg::LCS_TOK_REQ, 3);
      wait_tok(1);
      chk("credit_tok", lcs_pkg::LCS_TOK_CREDIT, FAR.last_tok);
      chk("sym_gap", 1, FAR.sgap_min >= 4);
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("issued", 1, d[26]);
   endtask : t_grant
   // Credit arrival seen in status, irq raised and cleared
   task t_held;
      wr(lcs_pkg::LCS_IRQ_EN_OFS, 32'h0000_0002);
      FAR.send(lcs_pkg::LCS_TOK_CREDIT, 3);
      repeat (8) @(posedge ref_clk);
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("held", 1, d[25]);
      rd(lcs_pkg::LCS_IRQ_STAT_OFS);
      chk("irq_stat", 1, d[1]);
      chk("irq_on", 1, irq);
      wr(lcs_pkg::LCS_IRQ_CLR_OFS, 32'h0000_0002);
      @(posedge ref_clk);
      chk("irq_off", 0, irq);
   endtask : t_held
   // Request write lands while a credit token is going out: two tokens in a row
   task t_credit_request_token;
      FAR.clr();
      FAR.send(lcs_pkg::LCS_TOK_REQ, 3);
      wr(lcs_pkg::LCS_CTRL_OFS, 32'h0100_1802);
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("drop_held", 32'h0400_1802, d);
      wait_tok(2);
      chk("req_tok", lcs_pkg::LCS_TOK_REQ, FAR.last_tok);
      chk("tok_gap", 1, FAR.tgap_min >= 3);
   endtask : t_credit_request_token
   // Stray symbol then receiver reset; later an illegal token
   task t_rx;
      FAR.send(6'h10, 1);
      wr(lcs_pkg::LCS_CTRL_OFS, 32'h0080_1802);
      FAR.clr();
      FAR.send(lcs_pkg::LCS_TOK_REQ, 3);
      wait_tok(1);
      chk("resync", lcs_pkg::LCS_TOK_CREDIT, FAR.last_tok);
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("no_err", 0, d[27]);
      FAR.send(6'h15, 3);
      repeat (4) @(posedge ref_clk);
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("err", 1, d[27]);
   endtask : t_rx
   // Data token out while credit is held, then one in while credit is granted
   task t_data;
      logic seen;
      seen = 1'b0;
      FAR.clr();
      tx_data_valid <= 1'b1;
      for (int i = 0; i < 100 && !seen; i++) begin
         @(posedge ref_clk);
         seen = tx_data_ready;
      end
      tx_data_valid <= 1'b0;
      chk("data_ready", 1, seen);
      wait_tok(1);
      chk("data_tok", lcs_pkg::LCS_TOK_DATA, FAR.last_tok);
      FAR.send(lcs_pkg::LCS_TOK_DATA, 3);
      repeat (2) @(posedge ref_clk);
      chk("rx_data", 1, n_rx);
   endtask : t_data
   // Reset in mid-run clears the sticky error; data with no grant is refused
   task t_rerst;
      wr(lcs_pkg::LCS_IRQ_EN_OFS, 32'h0000_0007);
      @(posedge ref_clk);
      chk("irq_err", 1, irq);
      srst <= 1'b1;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("ctrl_rerst", 32'h0000_0801, d);
      chk("irq_rerst", 0, irq);
      FAR.send(lcs_pkg::LCS_TOK_DATA, 3);
      repeat (4) @(posedge ref_clk);
      rd(lcs_pkg::LCS_CTRL_OFS);
      chk("ovf_err", 1, d[27]);
      chk("rx_refused", 1, n_rx);
   endtask : t_rerst
   // ==========================================
   // Clock, watchdog and main sequence
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      conclude();
   end
   initial begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_data_valid = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset();
      t_gaps();
      t_grant();
      t_held();
      t_data();
      t_credit_request_token();
      t_rx();
      t_rerst();
      conclude();
   end
endmodule : test_link_control_status
